/* design/pse_map.svh */
// constants for the l2 / system performance event qualifier
`ifndef PSE_MAP_SVH
`define PSE_MAP_SVH
// ----------------------------------------------------------------
// event codes
// ----------------------------------------------------------------
`define PSE_EV_MEM_REQ_TYPE   8'h65
`define PSE_EV_DATA_PREFETCH  8'h67
`define PSE_EV_BUF_REQUESTS   8'h68
`define PSE_EV_BUF_WAIT       8'h69
`define PSE_EV_REFILL_RESP    8'h6C
`define PSE_EV_OCTWORD_WRITE  8'h6D
`define PSE_EV_NOT_HALTED     8'h76
`define PSE_EV_L2_REQUEST     8'h7D
`define PSE_EV_L2_MISS        8'h7E
// ----------------------------------------------------------------
// sub-event bit positions
// ----------------------------------------------------------------
`define PSE_MEM_UNCACHEABLE_BIT   0
`define PSE_MEM_WR_COMBINING_BIT  1
`define PSE_MEM_STREAMING_BIT     7
`define PSE_PF_CANCEL_BIT         0
`define PSE_PF_ATTEMPT_BIT        1
`define PSE_OCTWORD_BIT           0
// ----------------------------------------------------------------
// miss buffer selection and reset values
// ----------------------------------------------------------------
`define PSE_BUF_COUNT        10
`define PSE_BUF_IDX_W        4
`define PSE_INC_RESET        3'h0
`define PSE_KNOWN_RESET      1'b0
`endif

/* design/pse_pkg.sv */
// types shared by the performance event qualifier modules
`include "pse_map.svh"
package pse_pkg;
  // selectable event codes
  typedef enum logic [7:0] {
    PSE_MEM_REQ_TYPE  = `PSE_EV_MEM_REQ_TYPE,
    PSE_DATA_PREFETCH = `PSE_EV_DATA_PREFETCH,
    PSE_BUF_REQUESTS  = `PSE_EV_BUF_REQUESTS,
    PSE_BUF_WAIT      = `PSE_EV_BUF_WAIT,
    PSE_REFILL_RESP   = `PSE_EV_REFILL_RESP,
    PSE_OCTWORD_WRITE = `PSE_EV_OCTWORD_WRITE,
    PSE_NOT_HALTED    = `PSE_EV_NOT_HALTED,
    PSE_L2_REQUEST    = `PSE_EV_L2_REQUEST,
    PSE_L2_MISS       = `PSE_EV_L2_MISS
  } pse_event_t;
  // one class bit per sub-event of a bitmask event
  typedef logic [7:0] pse_class_t;
endpackage

/* design/pse_match_if.sv */
// carrier between the event mux and the sub-event matcher
`timescale 1ns/1ps
interface pse_match_if;
  pse_pkg::pse_class_t class_vec;  // occurrences this cycle
  pse_pkg::pse_class_t mask;       // software sub-event mask
  logic                hit;        // any selected class occurred
  modport src   (output class_vec, output mask, input hit);
  modport match (input class_vec, input mask, output hit);
endinterface

/* design/pse_match.sv */
// sub-event matcher: selected sub-events combine as a logical or
`timescale 1ns/1ps
module pse_match
(
  pse_match_if.match m
);
  // ----------------------------------------------------------------
  // any-of match
  // ----------------------------------------------------------------
  // one increment per cycle even if several classes fire at once
  assign m.hit = |(m.class_vec & m.mask);
endmodule

/* design/pse_top.sv */
// performance event qualifier for l2 and system interface events
// Operation
// - 065h bits: uncacheable, combining, streaming store
// - combining events count flushes, not stores
// - combining counts all flushes; streaming only stream
// - 067h bit1 attempts, bit0 cancelled prefetches
// - 068h counts requests, 069h wait cycles
// - miss buffer events decode mask as index
// - 06Ch one per line, mask picks state
// - modified responses include store-intent refills
// - 06Dh counts each 16-byte write beat
// - 076h counts every clock not halted
// - 07Dh read requests by six request kinds
// - retried l2 requests also counted
// - 07Eh l2 misses by four request kinds
`timescale 1ns/1ps
`include "pse_map.svh"
module pse_top
#(
  parameter int BUF_COUNT = `PSE_BUF_COUNT  // miss address buffers
)
(
  input  wire logic                 i_mclk,
  input  wire logic                 i_rstn,
  // software selection
  input  wire logic [7:0]           i_event_code,
  input  wire logic [7:0]           i_sub_event_mask,
  // memory request type sources
  input  wire logic                 i_uncacheable_req,
  input  wire logic                 i_write_combining_flush,
  input  wire logic                 i_flush_by_stream,
  // data prefetcher
  input  wire logic                 i_pf_attempt,
  input  wire logic                 i_pf_cancel,
  // miss address buffers
  input  wire logic [BUF_COUNT-1:0] i_miss_address_buffer_req,
  input  wire logic [BUF_COUNT-1:0] i_miss_address_buffer_busy,
  // refill responses, one-hot {err,owned,shared,modified,excl}
  input  wire logic                 i_refill_resp,
  input  wire logic [4:0]           i_refill_state,
  // octword beats to the system this cycle, 0..4
  input  wire logic [2:0]           i_octword_beats,
  // halt sources
  input  wire logic                 i_stop_clock_request,
  input  wire logic                 i_halt_instruction,
  // l2 request and miss traffic
  input  wire logic                 i_l2_req,
  input  wire logic                 i_l2_retry,
  input  wire logic                 i_l2_req_read,
  input  wire logic [5:0]           i_l2_req_kind,
  input  wire logic                 i_l2_miss,
  input  wire logic [3:0]           i_l2_miss_kind,
  // counter increment
  output logic [2:0]                o_inc,
  output logic                      o_event_known
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // miss buffer index in range; used for both buffer events
  function automatic logic buf_idx_ok(input logic [7:0] mask);
    buf_idx_ok = (mask < 8'(BUF_COUNT));
  endfunction

  // registered outputs
  logic [2:0] inc_r;          // increment for the selected counter
  logic [2:0] inc_nxt;
  logic       known_r;        // selected code is one of ours
  logic       known_nxt;

  pse_match_if mif ();        // carrier to the matcher

  // ----------------------------------------------------------------
  // per-event class vectors
  // ----------------------------------------------------------------
  // flushes with the stream flag count under both combining bits
  wire pse_pkg::pse_class_t mem_cls;
  assign mem_cls = {i_write_combining_flush & i_flush_by_stream,
                    5'h00,
                    i_write_combining_flush,
                    i_uncacheable_req};

  // cancelled prefetches are also attempts
  wire pse_pkg::pse_class_t pf_cls;
  assign pf_cls = {6'h00, i_pf_attempt, i_pf_cancel};

  // each response carries one line; state from the one-hot field
  // modified covers store misses and write-intent prefetches
  wire pse_pkg::pse_class_t resp_cls;
  assign resp_cls = {3'h0, i_refill_resp ? i_refill_state
                                          : 5'h00};

  // writes never count; retries count like first attempts
  wire l2_req_any;
  assign l2_req_any = (i_l2_req | i_l2_retry) & i_l2_req_read;
  wire pse_pkg::pse_class_t l2r_cls;
  assign l2r_cls = {2'h0, l2_req_any ? i_l2_req_kind : 6'h00};

  wire pse_pkg::pse_class_t l2m_cls;
  assign l2m_cls = {4'h0, i_l2_miss ? i_l2_miss_kind : 4'h0};

  // ----------------------------------------------------------------
  // event selection
  // ----------------------------------------------------------------
  wire is_mem;
  wire is_pf;
  wire is_resp;
  wire is_l2r;
  wire is_l2m;
  wire is_mreq;
  wire is_mwait;
  wire is_oct;
  wire is_run;
  assign is_mem   = (i_event_code == `PSE_EV_MEM_REQ_TYPE);
  assign is_pf    = (i_event_code == `PSE_EV_DATA_PREFETCH);
  assign is_resp  = (i_event_code == `PSE_EV_REFILL_RESP);
  assign is_l2r   = (i_event_code == `PSE_EV_L2_REQUEST);
  assign is_l2m   = (i_event_code == `PSE_EV_L2_MISS);
  assign is_mreq  = (i_event_code == `PSE_EV_BUF_REQUESTS);
  assign is_mwait = (i_event_code == `PSE_EV_BUF_WAIT);
  assign is_oct   = (i_event_code == `PSE_EV_OCTWORD_WRITE);
  assign is_run   = (i_event_code == `PSE_EV_NOT_HALTED);

  // pick the class vector of the selected bitmask event
  wire pse_pkg::pse_class_t sel_cls;
  assign sel_cls = is_mem  ? mem_cls  :
                   is_pf   ? pf_cls   :
                   is_resp ? resp_cls :
                   is_l2r  ? l2r_cls  :
                   is_l2m  ? l2m_cls  : 8'h00;

  assign mif.class_vec = sel_cls;
  assign mif.mask      = i_sub_event_mask;

  // bitmask matching lives in its own module
  pse_match u_match
  (
    .m (mif.match)
  );

  // ----------------------------------------------------------------
  // miss address buffer selection
  // ----------------------------------------------------------------
  // mask is an index, not bits; combined values just pick a buffer
  // that may not exist, so software must program one index
  wire                      buf_ok;
  wire [`PSE_BUF_IDX_W-1:0] buf_idx;
  wire                      buf_req_sel;
  wire                      buf_busy_sel;
  assign buf_ok       = buf_idx_ok(i_sub_event_mask);
  assign buf_idx      = i_sub_event_mask[`PSE_BUF_IDX_W-1:0];
  assign buf_req_sel  = buf_ok & i_miss_address_buffer_req[buf_idx];
  assign buf_busy_sel = buf_ok & i_miss_address_buffer_busy[buf_idx];

  // ----------------------------------------------------------------
  // other selections
  // ----------------------------------------------------------------
  // halted by either source stops the clock event
  wire not_halted;
  assign not_halted = ~(i_stop_clock_request | i_halt_instruction);

  // one increment per 16-byte beat, up to four
  wire [2:0] oct_amt;
  assign oct_amt = i_sub_event_mask[`PSE_OCTWORD_BIT] ? i_octword_beats
                                                      : 3'h0;

  // ----------------------------------------------------------------
  // increment mux
  // ----------------------------------------------------------------
  always_comb
  begin
    inc_nxt   = 3'h0;
    known_nxt = 1'b1;
    if (is_mem | is_pf | is_resp | is_l2r | is_l2m)
    begin
      inc_nxt = {2'h0, mif.hit};
    end
    else if (is_mreq)
    begin
      inc_nxt = {2'h0, buf_req_sel};
    end
    else if (is_mwait)
    begin
      inc_nxt = {2'h0, buf_busy_sel};
    end
    else if (is_oct)
    begin
      inc_nxt = oct_amt;
    end
    else if (is_run)
    begin
      inc_nxt = {2'h0, not_halted};
    end
    else
    begin
      // codes outside this group never count here
      known_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // one cycle of latency keeps the counter path off the event logic
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      inc_r   <= `PSE_INC_RESET;
      known_r <= `PSE_KNOWN_RESET;
    end
    else
    begin
      inc_r   <= inc_nxt;
      known_r <= known_nxt;
    end
  end

  assign o_inc         = inc_r;
  assign o_event_known = known_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  // a streaming flush seen with only the streaming bit selected
  sequence stream_flush_s;
    is_mem && i_sub_event_mask == 8'h80 &&
      i_write_combining_flush && i_flush_by_stream;
  endsequence

  uncacheable_req_a: assert property (
    is_mem && i_sub_event_mask == 8'h01 |=> o_inc == {2'h0,
      $past(i_uncacheable_req)})
    else $error("uncacheable request count wrong");
  stream_flush_a: assert property (stream_flush_s |=> o_inc == 3'h1)
    else $error("streaming flush not counted");
  comb_flush_only_a: assert property (
    is_mem && i_sub_event_mask == 8'h82 && !i_write_combining_flush
      && !i_uncacheable_req |=> o_inc == 3'h0)
    else $error("combining counted without a flush");
  pf_cancel_a: assert property (
    is_pf && i_sub_event_mask == 8'h01 |=> o_inc[0] ==
      $past(i_pf_cancel))
    else $error("cancelled prefetch count wrong");
  buf_wait_a: assert property (
    (is_mwait && i_sub_event_mask == 8'h01 &&
      i_miss_address_buffer_busy[1]) [*2] |-> o_inc == 3'h1)
    else $error("buffer wait cycle not counted");
  buf_range_a: assert property (
    (is_mreq || is_mwait) && i_sub_event_mask > 8'h09 |=>
      o_inc == 3'h0)
    else $error("out of range buffer index counted");
  refill_owned_a: assert property (
    is_resp && i_sub_event_mask == 8'h08 |=> o_inc == {2'h0,
      $past(i_refill_resp) && $past(i_refill_state[3])})
    else $error("owned refill count wrong");
  octword_beats_a: assert property (
    is_oct && i_sub_event_mask[0] |=> o_inc == $past(i_octword_beats))
    else $error("octword beats not passed through");
  halted_clock_a: assert property (
    is_run && (i_stop_clock_request || i_halt_instruction) |=>
      o_inc == 3'h0)
    else $error("halted clock counted");
  l2_write_a: assert property (
    is_l2r && !i_l2_req_read |=> o_inc == 3'h0)
    else $error("l2 write request counted");
  l2_retry_a: assert property (
    is_l2r && i_sub_event_mask == 8'h02 && i_l2_retry &&
      i_l2_req_read && i_l2_req_kind[1] |=> o_inc == 3'h1)
    else $error("l2 retry not counted");
  l2_miss_a: assert property (
    is_l2m && i_sub_event_mask == 8'h08 |=> o_inc == {2'h0,
      $past(i_l2_miss) && $past(i_l2_miss_kind[3])})
    else $error("l2 prefetch miss count wrong");
  unknown_code_a: assert property (
    !known_nxt |=> o_inc == 3'h0 && !o_event_known)
    else $error("unknown code produced a count");
endmodule

/* dv/pse_tb.sv */
// self-checking bench for the performance event qualifier
`timescale 1ns/1ps
`define CHK(nm, exp, act) \
  begin \
    comparisons++; \
    if ((act) !== (exp)) \
    begin \
      fail_count++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, exp, act); \
    end \
  end
module testbench;
  // ------------------------------------------------------------
  // stimulus flags, one bit per event source
  // ------------------------------------------------------------
  localparam logic [15:0] E_NONE  = 16'h0000;
  localparam logic [15:0] E_UNC   = 16'h0001;  // uncacheable request
  localparam logic [15:0] E_WCF   = 16'h0002;  // combining flush
  localparam logic [15:0] E_STRM  = 16'h0004;  // flush filled by stream
  localparam logic [15:0] E_PFA   = 16'h0008;  // prefetch attempt
  localparam logic [15:0] E_PFC   = 16'h0010;  // prefetch cancelled
  localparam logic [15:0] E_RESP  = 16'h0020;  // refill line returned
  localparam logic [15:0] E_STOP  = 16'h0040;  // stop clock halt
  localparam logic [15:0] E_HALT  = 16'h0080;  // halt instruction
  localparam logic [15:0] E_REQ   = 16'h0100;  // l2 request
  localparam logic [15:0] E_RETRY = 16'h0200;  // l2 retried request
  localparam logic [15:0] E_RD    = 16'h0400;  // l2 request is a read
  localparam logic [15:0] E_MISS  = 16'h0800;  // l2 miss
  localparam logic [15:0] E_BUSY  = 16'h1000;  // buffers waiting, no req
  logic       i_mclk;
  logic       i_rstn;
  logic [7:0] i_event_code;
  logic [7:0] i_sub_event_mask;
  logic [15:0] ev_r;                          // flags of this step
  logic [9:0] i_miss_address_buffer_req;
  logic [9:0] i_miss_address_buffer_busy;
  logic [5:0] kind_r;                         // shared kind / beats
  logic [2:0] o_inc;
  logic       o_event_known;
  int         fail_count;
  int         comparisons;
  // ------------------------------------------------------------
  // design, clock and watchdog
  // ------------------------------------------------------------
  pse_top dut
  (
    .i_mclk                     (i_mclk),
    .i_rstn                     (i_rstn),
    .i_event_code               (i_event_code),
    .i_sub_event_mask           (i_sub_event_mask),
    .i_uncacheable_req          (ev_r[0]),
    .i_write_combining_flush    (ev_r[1]),
    .i_flush_by_stream          (ev_r[2]),
    .i_pf_attempt               (ev_r[3]),
    .i_pf_cancel                (ev_r[4]),
    .i_miss_address_buffer_req  (i_miss_address_buffer_req),
    .i_miss_address_buffer_busy (i_miss_address_buffer_busy),
    .i_refill_resp              (ev_r[5]),
    .i_refill_state             (kind_r[4:0]),
    .i_octword_beats            (kind_r[2:0]),
    .i_stop_clock_request       (ev_r[6]),
    .i_halt_instruction         (ev_r[7]),
    .i_l2_req                   (ev_r[8]),
    .i_l2_retry                 (ev_r[9]),
    .i_l2_req_read              (ev_r[10]),
    .i_l2_req_kind              (kind_r),
    .i_l2_miss                  (ev_r[11]),
    .i_l2_miss_kind             (kind_r[3:0]),
    .o_inc                      (o_inc),
    .o_event_known              (o_event_known)
  );
  // 25 MHz core clock
  always #20 i_mclk = ~i_mclk;
  // cut a hang short; the whole run needs well under this
  initial
  begin
    repeat (4000) @(posedge i_mclk);
    fail_count++;
    end_sim();
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // codes that belong to this event group
  function automatic logic known(input logic [7:0] code);
    case (code)
      8'h65, 8'h67, 8'h68, 8'h69, 8'h6C, 8'h6D, 8'h76, 8'h7D, 8'h7E:
        return 1'b1;
      default:
        return 1'b0;
    endcase
  endfunction
  // one step: drive at an edge, check the registered answer one edge on
  task automatic go(input logic [7:0] code, input logic [7:0] mask,
                    input logic [15:0] ev, input logic [9:0] bufs,
                    input logic [5:0] kind, input logic [2:0] exp);
    @(posedge i_mclk);
    i_event_code               <= code;
    i_sub_event_mask           <= mask;
    ev_r                       <= ev;
    kind_r                     <= kind;
    i_miss_address_buffer_req  <= ev[12] ? 10'h000 : bufs;
    i_miss_address_buffer_busy <= ev[12] ? bufs : 10'h000;
    @(posedge i_mclk);
    #1;
    `CHK("o_inc", exp, o_inc)
    `CHK("o_event_known", known(code), o_event_known)
  endtask
  // verdict and end of run
  task automatic end_sim();
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    i_mclk = 1'b0;
    i_rstn = 1'b0;
    i_event_code = 8'h76;  // counts every clock, so reset must mask it
    i_sub_event_mask = 8'h00;
    ev_r = 16'h0000;
    kind_r = 6'h00;
    i_miss_address_buffer_req = 10'h000;
    i_miss_address_buffer_busy = 10'h000;
    fail_count = 0;
    comparisons = 0;
    repeat (20) @(posedge i_mclk);
    `CHK("o_inc", 3'h0, o_inc)
    i_rstn <= 1'b1;
    // memory request types and combining flushes
    go(8'h65, 8'h01, E_UNC, 10'h000, 6'h00, 3'h1);
    go(8'h65, 8'h01, E_WCF, 10'h000, 6'h00, 3'h0);
    go(8'h65, 8'h80, E_UNC, 10'h000, 6'h00, 3'h0);
    go(8'h65, 8'h02, E_UNC, 10'h000, 6'h00, 3'h0);
    go(8'h65, 8'h02, E_WCF, 10'h000, 6'h00, 3'h1);
    go(8'h65, 8'h80, E_STRM, 10'h000, 6'h00, 3'h0);
    go(8'h65, 8'h82, E_STRM, 10'h000, 6'h00, 3'h0);
    go(8'h65, 8'h02, E_WCF | E_STRM, 10'h000, 6'h00, 3'h1);
    go(8'h65, 8'h80, E_WCF, 10'h000, 6'h00, 3'h0);
    go(8'h65, 8'h80, E_WCF | E_STRM, 10'h000, 6'h00, 3'h1);
    go(8'h65, 8'h83, E_UNC | E_WCF | E_STRM, 10'h000, 6'h00, 3'h1);
    // prefetcher: an attempt is flagged with every cancel
    go(8'h67, 8'h02, E_PFA, 10'h000, 6'h00, 3'h1);
    go(8'h67, 8'h01, E_PFA, 10'h000, 6'h00, 3'h0);
    go(8'h67, 8'h01, E_PFA | E_PFC, 10'h000, 6'h00, 3'h1);
    go(8'h67, 8'h02, E_NONE, 10'h000, 6'h00, 3'h0);
    // miss buffers: mask is an index, others must not leak in
    for (int i = 0; i < 10; i++)
    begin
      go(8'h68, 8'(i), E_NONE, 10'h001 << i, 6'h00, 3'h1);
      go(8'h68, 8'(i), E_NONE, ~(10'h001 << i), 6'h00, 3'h0);
      go(8'h69, 8'(i), E_BUSY, 10'h001 << i, 6'h00, 3'h1);
      go(8'h69, 8'(i), E_NONE, 10'h001 << i, 6'h00, 3'h0);
    end
    go(8'h68, 8'h0A, E_NONE, 10'h3FF, 6'h00, 3'h0);
    go(8'h69, 8'h0F, E_BUSY, 10'h3FF, 6'h00, 3'h0);
    // refill responses by state, modified among them
    for (int b = 0; b < 5; b++)
    begin
      go(8'h6C, 8'h01 << b, E_RESP, 10'h000, 6'h01 << b, 3'h1);
      go(8'h6C, 8'h01 << b, E_RESP, 10'h000,
         6'h01 << (b + 1) % 5, 3'h0);
      go(8'h6C, 8'h01 << b, E_NONE, 10'h000, 6'h01 << b, 3'h0);
    end
    // octword beats pass through, 0 to 4
    for (int n = 0; n < 5; n++)
      go(8'h6D, 8'h01, E_NONE, 10'h000, 6'(n), 3'(n));
    go(8'h6D, 8'h00, E_NONE, 10'h000, 6'h04, 3'h0);
    // non-halted clocks
    go(8'h76, 8'h00, E_NONE, 10'h000, 6'h00, 3'h1);
    go(8'h76, 8'h00, E_STOP, 10'h000, 6'h00, 3'h0);
    go(8'h76, 8'h00, E_HALT, 10'h000, 6'h00, 3'h0);
    go(8'h76, 8'hFF, E_STOP | E_HALT, 10'h000, 6'h00, 3'h0);
    // l2 read requests, retries and misses
    for (int b = 0; b < 6; b++)
    begin
      go(8'h7D, 8'h01 << b, E_REQ | E_RD, 10'h000, 6'h01 << b, 3'h1);
      go(8'h7D, 8'h01 << b, E_REQ, 10'h000, 6'h01 << b, 3'h0);
      go(8'h7D, 8'h01 << b, E_REQ | E_RD, 10'h000,
         6'h01 << (b + 1) % 6, 3'h0);
      go(8'h7D, 8'h01 << b, E_RETRY | E_RD, 10'h000, 6'h01 << b, 3'h1);
    end
    go(8'h7D, 8'h02, E_REQ | E_RETRY | E_RD, 10'h000, 6'h02, 3'h1);
    go(8'h7D, 8'h3F, E_REQ | E_RD, 10'h000, 6'h04, 3'h1);
    for (int b = 0; b < 4; b++)
    begin
      go(8'h7E, 8'h01 << b, E_MISS, 10'h000, 6'h01 << b, 3'h1);
      go(8'h7E, 8'h01 << b, E_MISS, 10'h000,
         6'h01 << (b + 1) % 4, 3'h0);
      go(8'h7E, 8'h01 << b, E_REQ | E_RD, 10'h000, 6'h01 << b, 3'h0);
    end
    // a code outside the group counts nothing
    go(8'h66, 8'hFF, 16'h0FFF, 10'h3FF, 6'h04, 3'h0);
    end_sim();
  end
endmodule
